// [core/isl_params.svh]
// constants of the two-wire slave interface
`ifndef ISL_PARAMS_SVH
`define ISL_PARAMS_SVH

// system clock and the bus rates the receiver must keep up with
`define ISL_CLK_KHZ 100000
`define ISL_STD_RATE_KHZ 100
`define ISL_FAST_RATE_KHZ 400
`define ISL_HS_RATE_KHZ 3400
// clk cycles in one high-speed bit period, rounded down (29)
`define ISL_HS_BIT_CYCLES (`ISL_CLK_KHZ / `ISL_HS_RATE_KHZ)

// byte framing
`define ISL_BYTE_W 8
`define ISL_CNT_W 4
`define ISL_CNT_ZERO 4'h0
`define ISL_CNT_ONE 4'h1
`define ISL_CNT_LAST 4'h7
`define ISL_CNT_FULL 4'h8

// address byte decoding
`define ISL_ADDR_W 7
`define ISL_GC_ADDR 7'h00
`define ISL_HS_CODE 5'h01
`define ISL_HS_CODE_W 5

// acknowledge phases
`define ISL_ACK_WAIT_FALL 2'h0
`define ISL_ACK_DRIVING 2'h1
`define ISL_ACK_RELEASE 2'h2

// receive buffer
`define ISL_FIFO_DEPTH 8

`endif

// [core/isl_pkg.sv]
// types shared by the two-wire slave interface
`include "isl_params.svh"

package isl_pkg;

    typedef enum logic [2:0] {
        ISL_IDLE,
        ISL_ADDR,
        ISL_ADDR_ACK,
        ISL_RX,
        ISL_RX_ACK,
        ISL_TX,
        ISL_TX_ACK,
        ISL_WAIT
    } isl_state_e;

    typedef struct packed {
        isl_state_e state;
        logic [`ISL_CNT_W-1:0] cnt;
        logic [`ISL_BYTE_W-1:0] shift;
        logic [1:0] ack_step;
        logic rw;
        logic hs;
        logic gcall;
        logic addressed;
        logic sda_oe;
        logic sda_lvl;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] tog_sync;
        logic scl_d;
        logic sda_d;
        logic tog_d;
        logic push;
        logic [`ISL_BYTE_W-1:0] push_data;
        logic tx_next;
        logic collision;
        logic rx_valid;
        logic [`ISL_BYTE_W-1:0] rx_data;
    } isl_core_s;

    typedef struct packed {
        logic bit_val;
        logic tog;
    } isl_cap_s;

endpackage

// [core/isl_slave.sv]
// two-wire bus slave: bit capture, receive fifo and protocol engine
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// bit capture on the bus clock itself
module isl_bit_capture
    import isl_pkg::*;
(
    input wire logic scl,
    input wire logic resetn,
    input wire logic sda_i,
    output logic bit_val,
    output logic tog
);

    isl_cap_s r;
    isl_cap_s next_r;

    always_comb begin
        next_r = r;
        next_r.bit_val = sda_i;
        // one toggle per rising edge tells the core a new bit is held
        next_r.tog = ~r.tog;
    end

    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bit_val = r.bit_val;
    assign tog = r.tog;

endmodule // isl_bit_capture

////////////////////////////////////////////////////////////////////////////
// receive fifo, valid and ready on both sides
module isl_fifo
    import isl_pkg::*;
#(
    parameter int WIDTH = `ISL_BYTE_W,
    parameter int DEPTH = `ISL_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } isl_fifo_s;

    isl_fifo_s r;
    isl_fifo_s next_r;
    logic full;
    logic empty;

    // the extra pointer bit tells a full buffer from an empty one
    assign full = (r.wptr[AW] != r.rptr[AW]) &&
                  (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
    assign empty = (r.wptr == r.rptr);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = r.mem[r.rptr[AW-1:0]];

    always_comb begin
        next_r = r;
        if (in_valid && !full) begin
            next_r.mem[r.wptr[AW-1:0]] = in_data;
            next_r.wptr = r.wptr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_r.rptr = r.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // isl_fifo

////////////////////////////////////////////////////////////////////////////
// protocol engine, top of the block
module isl_slave
    import isl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [`ISL_ADDR_W-1:0] own_addr,
    input wire logic nv_busy,
    input wire logic nv_cmd_ok,
    input wire logic [`ISL_BYTE_W-1:0] tx_data,
    output logic tx_next,
    output logic [`ISL_BYTE_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic hs_mode,
    output logic addressed,
    output logic gen_call,
    output logic collision
);

    isl_core_s r;
    isl_core_s next_r;

    logic cap_bit;
    logic cap_tog;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`ISL_BYTE_W-1:0] fifo_out_data;
    logic fifo_out_ready;

    logic scl_hi;
    logic start_ev;
    logic stop_ev;
    logic scl_fall;
    logic bit_ev;
    logic [`ISL_BYTE_W-1:0] byte_in;

    isl_bit_capture u_cap (
        .scl(scl),
        .resetn(resetn),
        .sda_i(sda_i),
        .bit_val(cap_bit),
        .tog(cap_tog)
    );

    isl_fifo #(
        .WIDTH(`ISL_BYTE_W),
        .DEPTH(`ISL_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(r.push),
        .in_data(r.push_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus events seen through the synchronisers

    // both lines pass the same two stages, so their order is kept
    assign scl_hi = r.scl_sync[1] & r.scl_d;
    assign start_ev = scl_hi & r.sda_d & ~r.sda_sync[1];
    assign stop_ev = scl_hi & ~r.sda_d & r.sda_sync[1];
    assign scl_fall = r.scl_d & ~r.scl_sync[1];
    // the captured bit holds until the next clock rise, far longer
    // than the toggle takes to cross, even at the fastest rate
    assign bit_ev = r.tog_sync[1] ^ r.tog_d;
    assign byte_in = {r.shift[`ISL_BYTE_W-2:0], cap_bit};
    assign fifo_out_ready = ~r.rx_valid | rx_ready;

    function automatic logic is_hs_code(input logic [`ISL_BYTE_W-1:0] b);
        is_hs_code = (b[`ISL_BYTE_W-1:`ISL_BYTE_W-`ISL_HS_CODE_W]
                      == `ISL_HS_CODE);
    endfunction

    function automatic logic is_gcall(input logic [`ISL_BYTE_W-1:0] b);
        is_gcall = (b[`ISL_BYTE_W-1:1] == `ISL_GC_ADDR) && !b[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], scl};
        next_r.sda_sync = {r.sda_sync[0], sda_i};
        next_r.tog_sync = {r.tog_sync[0], cap_tog};
        next_r.scl_d = r.scl_sync[1];
        next_r.sda_d = r.sda_sync[1];
        next_r.tog_d = r.tog_sync[1];
        next_r.push = 1'b0;
        next_r.tx_next = 1'b0;
        next_r.collision = 1'b0;
        next_r.sda_lvl = 1'b0;

        // output stage keeps rx_data and rx_valid on flops
        if (fifo_out_valid && fifo_out_ready) begin
            next_r.rx_valid = 1'b1;
            next_r.rx_data = fifo_out_data;
        end else if (rx_ready) begin
            next_r.rx_valid = 1'b0;
        end

        case (r.state)
            ISL_ADDR: begin
                if (bit_ev) begin
                    next_r.shift = byte_in;
                    next_r.cnt = r.cnt + `ISL_CNT_ONE;
                    if (r.cnt == `ISL_CNT_LAST) begin
                        next_r.ack_step = `ISL_ACK_WAIT_FALL;
                        next_r.rw = byte_in[0];
                        if (is_hs_code(byte_in)) begin
                            // master code is never acknowledged
                            next_r.hs = 1'b1;
                            next_r.state = ISL_WAIT;
                        end else if (is_gcall(byte_in)) begin
                            next_r.gcall = 1'b1;
                            next_r.state = ISL_ADDR_ACK;
                        end else if (byte_in[`ISL_BYTE_W-1:1]
                                     == own_addr) begin
                            next_r.addressed = 1'b1;
                            next_r.state = ISL_ADDR_ACK;
                        end else begin
                            next_r.state = ISL_WAIT;
                        end
                    end
                end
            end

            ISL_ADDR_ACK, ISL_RX_ACK: begin
                case (r.ack_step)
                    `ISL_ACK_WAIT_FALL: begin
                        if (scl_fall) begin
                            next_r.sda_oe = 1'b1;
                            next_r.ack_step = `ISL_ACK_DRIVING;
                        end
                    end
                    `ISL_ACK_DRIVING: begin
                        if (bit_ev) begin
                            next_r.ack_step = `ISL_ACK_RELEASE;
                        end
                    end
                    default: begin
                        if (scl_fall) begin
                            next_r.ack_step = `ISL_ACK_WAIT_FALL;
                            next_r.cnt = `ISL_CNT_ZERO;
                            if (r.state == ISL_ADDR_ACK && r.rw) begin
                                // first read bit goes out on this fall
                                next_r.state = ISL_TX;
                                next_r.shift = tx_data;
                                next_r.sda_oe =
                                    ~tx_data[`ISL_BYTE_W-1];
                                next_r.tx_next = 1'b1;
                            end else begin
                                next_r.state = ISL_RX;
                                next_r.sda_oe = 1'b0;
                            end
                        end
                    end
                endcase
            end

            ISL_RX: begin
                if (bit_ev) begin
                    next_r.shift = byte_in;
                    next_r.cnt = r.cnt + `ISL_CNT_ONE;
                    if (r.cnt == `ISL_CNT_LAST) begin
                        // a full buffer refuses the byte instead of
                        // stretching the clock, which we never drive
                        if (fifo_in_ready &&
                            (!nv_busy || nv_cmd_ok)) begin
                            next_r.push = 1'b1;
                            next_r.push_data = byte_in;
                            next_r.ack_step = `ISL_ACK_WAIT_FALL;
                            next_r.state = ISL_RX_ACK;
                        end else begin
                            next_r.state = ISL_WAIT;
                        end
                    end
                end
            end

            ISL_TX: begin
                if (bit_ev) begin
                    if (!r.sda_oe && !cap_bit) begin
                        // released a one but saw a zero
                        next_r.collision = 1'b1;
                        next_r.state = ISL_WAIT;
                    end else begin
                        next_r.shift = {r.shift[`ISL_BYTE_W-2:0], 1'b0};
                        next_r.cnt = r.cnt + `ISL_CNT_ONE;
                    end
                end else if (scl_fall) begin
                    if (r.cnt < `ISL_CNT_FULL) begin
                        next_r.sda_oe = ~r.shift[`ISL_BYTE_W-1];
                    end else begin
                        next_r.sda_oe = 1'b0;
                        next_r.state = ISL_TX_ACK;
                    end
                end
            end

            ISL_TX_ACK: begin
                if (bit_ev) begin
                    if (!cap_bit) begin
                        next_r.state = ISL_TX;
                        next_r.cnt = `ISL_CNT_ZERO;
                        next_r.shift = tx_data;
                        next_r.tx_next = 1'b1;
                    end else begin
                        // master refused: nothing more until a condition
                        next_r.state = ISL_WAIT;
                    end
                end
            end

            ISL_IDLE, ISL_WAIT: begin
                next_r.sda_oe = 1'b0;
            end

            default: begin
                next_r.state = ISL_IDLE;
                next_r.sda_oe = 1'b0;
            end
        endcase

        // conditions override whatever the byte engine was doing
        if (start_ev) begin
            // covers a repeated start too; high speed stays on
            next_r.state = ISL_ADDR;
            next_r.cnt = `ISL_CNT_ZERO;
            next_r.ack_step = `ISL_ACK_WAIT_FALL;
            next_r.sda_oe = 1'b0;
            next_r.addressed = 1'b0;
            next_r.gcall = 1'b0;
        end else if (stop_ev) begin
            next_r.state = ISL_IDLE;
            next_r.cnt = `ISL_CNT_ZERO;
            next_r.ack_step = `ISL_ACK_WAIT_FALL;
            next_r.sda_oe = 1'b0;
            next_r.addressed = 1'b0;
            next_r.gcall = 1'b0;
            next_r.hs = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign sda_o = r.sda_lvl;
    assign sda_oe = r.sda_oe;
    assign tx_next = r.tx_next;
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;
    assign hs_mode = r.hs;
    assign addressed = r.addressed;
    assign gen_call = r.gcall;
    assign collision = r.collision;

endmodule // isl_slave

// [verification/isl_slave_assertions.sv]
// concurrent checks on the ports of the two-wire slave
`timescale 1ns/1ns
module isl_slave_assertions
    import isl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic tx_next,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic hs_mode,
    input wire logic addressed,
    input wire logic collision
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_stop;
        scl && $past(scl) && sda_i && !$past(sda_i);
    endsequence
    sequence s_start;
        scl && $past(scl) && !sda_i && $past(sda_i);
    endsequence
    property p_pull_only;
        sda_o == 1'b0;
    endproperty
    property p_stop_clears;
        s_stop |-> ##[1:6] (!hs_mode && !addressed);
    endproperty
    property p_start_clears;
        s_start |-> ##[1:6] !addressed;
    endproperty
    property p_oe_clock_low;
        $changed(sda_oe) |-> !scl;
    endproperty
    property p_drive_stands;
        $rose(sda_oe) |-> sda_oe [*8];
    endproperty
    property p_tx_pulse;
        tx_next |=> !tx_next;
    endproperty
    property p_tx_owner;
        tx_next |-> addressed;
    endproperty
    property p_coll_pulse;
        collision |=> !collision;
    endproperty
    property p_coll_release;
        collision |-> ##[0:8] !sda_oe;
    endproperty
    property p_rx_hold;
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
    endproperty
    a_pull_only: assert property (p_pull_only)
        else $error("data line driven high");
    a_stop_clears: assert property (p_stop_clears)
        else $error("stop did not reset the interface");
    a_start_clears: assert property (p_start_clears)
        else $error("start did not reset the command state");
    a_oe_clock_low: assert property (p_oe_clock_low)
        else $error("data drive changed with clock high");
    a_drive_stands: assert property (p_drive_stands)
        else $error("low drive too short");
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("tx_next longer than one cycle");
    a_tx_owner: assert property (p_tx_owner)
        else $error("read load while not addressed");
    a_coll_pulse: assert property (p_coll_pulse)
        else $error("collision longer than one cycle");
    a_coll_release: assert property (p_coll_release)
        else $error("line held after collision");
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx word changed before taken");
endmodule // isl_slave_assertions

bind isl_slave isl_slave_assertions i_chk (.clk(clk), .resetn(resetn),
    .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .tx_next(tx_next), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .hs_mode(hs_mode), .addressed(addressed),
    .collision(collision));

// [verification/isl_master_model.sv]
// bus master model: clock, conditions and bytes at about 3.3 MHz
`timescale 1ns/1ns
module isl_master_model (
    input wire logic clk,
    output logic scl,
    output logic pull,
    input wire logic sda
);
    // quarter bit: keeps each clock phase above 8 system clocks
    localparam int Q = 75;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // only the master makes clock and conditions
    task automatic put_bit(input logic b, output logic got);
        #Q pull = !b; // data moves only while clock low
        #Q scl = 1'b1;
        #Q got = sda;
        #Q scl = 1'b0;
    endtask
    // every frame step starts just off a system clock edge, so no line
    // moves in the time step in which the flops sample it
    task automatic align();
        @(posedge clk);
        #2;
    endtask
    task automatic start();
        align();
        #Q pull = 1'b0;
        #Q scl = 1'b1;
        #Q pull = 1'b1; // data falls with clock high
        #Q scl = 1'b0;
    endtask
    task automatic stop();
        align();
        #Q pull = 1'b1;
        #Q scl = 1'b1;
        #Q pull = 1'b0; // data rises with clock high
        #Q;
    endtask
    // msb first, then the ninth bit; FFh sent means line released
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack_out);
        logic lost;
        align();
        lost = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i] | lost, q[i]);
            // a one read back as zero: another driver won, so stop
            // driving and keep listening
            lost = lost | (d[i] & !q[i]);
        end
        put_bit(ack_in, ack_out);
    endtask
endmodule // isl_master_model

// [verification/isl_slave_bench.sv]
// self-checking bench of the two-wire slave
`timescale 1ns/1ns
module isl_slave_bench;
    import isl_pkg::*;
    logic clk, resetn, scl, m_pull, sda_o, sda_oe, nv_busy, nv_cmd_ok;
    logic rx_ready, tx_next, rx_valid, hs_mode, addressed, gen_call;
    logic collision, hold_rx, coll_seen;
    logic [7:0] tx_data, rx_data, q, e;
    logic [6:0] own_addr;
    logic a;
    logic [31:0] seed;
    int bad_count, checked;
    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];
    // pull-up: released line reads high
    wire sda = !(m_pull | sda_oe);

    isl_slave i_dut (.clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .own_addr(own_addr),
        .nv_busy(nv_busy), .nv_cmd_ok(nv_cmd_ok), .tx_data(tx_data),
        .tx_next(tx_next), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .hs_mode(hs_mode), .addressed(addressed),
        .gen_call(gen_call), .collision(collision));
    isl_master_model i_m (.clk(clk), .scl(scl), .pull(m_pull),
        .sda(sda));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [7:0] ev, input logic [7:0] g);
        checked++;
        if (g !== ev) begin
            bad_count++;
            $display("mismatch at %0t: expected %h got %h", $time, ev, g);
        end
    endtask
    task automatic chk1(input logic ev, input logic g);
        checked++;
        if (g !== ev) begin
            bad_count++;
            $display("mismatch at %0t: expected %h got %h", $time, ev, g);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d, input logic ev);
        logic [7:0] r;
        logic k;
        i_m.xfer(d, 1'b1, r, k);
        chk1(ev, k);
    endtask
    // random data byte, noted for the stream monitor when acked
    task automatic wd(input logic ev);
        logic [7:0] d;
        d = seed[23:16];
        if (!ev) begin
            rx_q.push_back(d);
        end
        wr(d, ev);
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // drivers and the stream monitor, all on the rising edge
    always @(posedge clk) begin
        seed <= rnd(seed);
        rx_ready <= !hold_rx && seed[3];
        if (tx_next === 1'b1) begin
            tx_q.push_back(tx_data);
            tx_data <= seed[15:8];
        end
        if (collision === 1'b1) begin
            coll_seen <= 1'b1;
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            chk(rx_q.pop_front(), rx_data);
        end
    end
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end
    initial begin
        resetn = 1'b0;
        rx_ready = 1'b0;
        tx_data = 8'h3C;
        own_addr = 7'h50;
        nv_busy = 1'b0;
        nv_cmd_ok = 1'b0;
        hold_rx = 1'b0;
        coll_seen = 1'b0;
        seed = 32'h27;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        // foreign address refused, bytes after it ignored
        i_m.start();
        wr(8'hA2, 1'b1);
        chk1(1'b0, addressed);
        wr(8'h11, 1'b1);
        // new start resets the machine; own address, data to the fifo
        i_m.start();
        wr(8'hA0, 1'b0);
        repeat (3) wd(1'b0);
        chk1(1'b1, addressed);
        // repeated start, read three bytes, last one refused by master
        i_m.start();
        wr(8'hA1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            i_m.xfer(8'hFF, i == 2, q, a);
            chk(tx_q.pop_front(), q);
        end
        // master holds the line low during a read bit of one
        i_m.start();
        wr(8'hA1, 1'b0);
        i_m.xfer(8'h00, 1'b1, q, a);
        e = tx_q.pop_front();
        chk1(|e, coll_seen);
        i_m.stop();
        // general call
        i_m.start();
        wr(8'h00, 1'b0);
        settle();
        chk1(1'b1, gen_call);
        i_m.stop();
        // master code: refused, then addressed at high speed until stop
        i_m.start();
        wr(8'h09, 1'b1);
        settle();
        chk1(1'b1, hs_mode);
        i_m.start();
        wr(8'hA0, 1'b0);
        i_m.stop();
        settle();
        chk1(1'b0, hs_mode);
        // nonvolatile write in progress
        nv_busy <= 1'b1;
        i_m.start();
        wr(8'hA0, 1'b0);
        wd(1'b1);
        @(posedge clk) nv_cmd_ok <= 1'b1;
        // the refusal leaves the engine waiting: a new start is needed
        i_m.start();
        wr(8'hA0, 1'b0);
        wd(1'b0);
        i_m.stop();
        @(posedge clk) nv_busy <= 1'b0;
        // fill while the reader stalls: eight words in the fifo and one
        // in the output stage, so the tenth byte is refused
        repeat (200) @(posedge clk);
        hold_rx <= 1'b1;
        i_m.start();
        wr(8'hA0, 1'b0);
        repeat (9) wd(1'b0);
        wd(1'b1);
        i_m.stop();
        hold_rx <= 1'b0;
        repeat (200) @(posedge clk);
        chk(8'h00, 8'(rx_q.size()));
        give_verdict();
    end
endmodule // isl_slave_bench
